/* rtl/bus_cycle_sequencer.sv */
`timescale 1ns/1ps
module bus_cycle_sequencer #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cpu_clock_halving_select,
  input wire logic [bus_phase_pkg::CFG_W-1:0] chip_select_timing_config,
  input wire logic window_changed,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic [DATA_W-1:0] bus_data_in,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] phase
);
  ////////////////////////////////////////////////////////////////////////
  logic cpu_tick;
  bus_phase_pkg::phase_t state;
  bus_phase_pkg::phase_t next_state;
  logic [bus_phase_pkg::CNT_W-1:0] cnt;
  logic [bus_phase_pkg::CNT_W-1:0] next_cnt;
  logic [bus_phase_pkg::CFG_W-1:0] cfg;
  logic is_write;
  logic last;

  cpu_clock_enable u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cpu_clock_halving_select(cpu_clock_halving_select),
    .cpu_tick(cpu_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // setup count from a raw config word: base 0 or 1, plus window extension
  function automatic logic [4:0] setup_cnt(
    input logic [bus_phase_pkg::CFG_W-1:0] word,
    input logic win
  );
    logic [1:0] ext;
    ext = win ? word[bus_phase_pkg::AX_LSB +: 2] : 2'h0;
    return 5'(word[bus_phase_pkg::AB_LSB]) + 5'(ext);
  endfunction

  // n programmed periods load the down counter with n - 1; never called
  // with zero, since zero-length phases are skipped
  function automatic logic [4:0] len_cnt(input logic [1:0] len);
    return 5'(len - 2'h1);
  endfunction

  // ab_cnt and e_len are phase length minus one, c, d and f are raw lengths; zero-length phases are skipped entirely
  // setup is taken from the raw inputs, cfg is only latched on that edge
  wire [4:0] ab_cnt = setup_cnt(chip_select_timing_config,
    window_changed);
  wire [1:0] c_len = cfg[bus_phase_pkg::C_LSB +: 2];
  wire d_len = cfg[bus_phase_pkg::D_LSB];
  wire [4:0] e_len = cfg[bus_phase_pkg::E_LSB +: 5];
  wire [1:0] f_len = cfg[bus_phase_pkg::F_LSB +: 2];

  assign last = cnt == 5'h00;
  assign req_ready = state == bus_phase_pkg::PH_IDLE;
  assign phase = state;

  ////////////////////////////////////////////////////////////////////////
  // next phase after the current one ends, skipping zero-length phases
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      bus_phase_pkg::PH_IDLE: begin
        if (req_valid) begin
          next_state = bus_phase_pkg::PH_AB;
          next_cnt = ab_cnt;
        end
      end
      bus_phase_pkg::PH_AB: begin
        if (last) begin
          if (c_len != 2'h0) begin
            next_state = bus_phase_pkg::PH_C;
            next_cnt = len_cnt(c_len);
          end else if (d_len) begin
            next_state = bus_phase_pkg::PH_D;
            next_cnt = 5'h00;
          end else begin
            next_state = bus_phase_pkg::PH_E;
            next_cnt = e_len;
          end
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      bus_phase_pkg::PH_C: begin
        if (last) begin
          if (d_len) begin
            next_state = bus_phase_pkg::PH_D;
            next_cnt = 5'h00;
          end else begin
            next_state = bus_phase_pkg::PH_E;
            next_cnt = e_len;
          end
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      bus_phase_pkg::PH_D: begin
        next_state = bus_phase_pkg::PH_E;
        next_cnt = e_len;
      end
      bus_phase_pkg::PH_E: begin
        if (last) begin
          if (f_len != 2'h0) begin
            next_state = bus_phase_pkg::PH_F;
            next_cnt = len_cnt(f_len);
          end else begin
            next_state = bus_phase_pkg::PH_IDLE;
          end
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      bus_phase_pkg::PH_F: begin
        if (last) begin
          next_state = bus_phase_pkg::PH_IDLE;
        end else begin
          next_cnt = cnt - 5'h01;
        end
      end
      default: begin
        next_state = bus_phase_pkg::PH_IDLE;
        next_cnt = 5'h00;
      end
    endcase
  end

  wire take = req_ready & req_valid & cpu_tick;
  wire e_end = state == bus_phase_pkg::PH_E && last && cpu_tick;
  wire enter_e = state != bus_phase_pkg::PH_E &&
    next_state == bus_phase_pkg::PH_E && cpu_tick;
  wire cycle_end = cpu_tick && state != bus_phase_pkg::PH_IDLE &&
    next_state == bus_phase_pkg::PH_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // phases only advance on cpu clock ticks, so lengths are whole periods
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= bus_phase_pkg::PH_IDLE;
      cnt <= 5'h00;
    end else if (cpu_tick) begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg <= bus_phase_pkg::CFG_RESET;
      is_write <= 1'b0;
      bus_addr <= '0;
      bus_data_out <= '0;
    end else if (take) begin
      // config latched per access so a mid-cycle change cannot tear it
      cfg <= chip_select_timing_config;
      is_write <= req_write;
      bus_addr <= req_addr;
      bus_data_out <= req_wdata;
    end
  end

  // strobes and write drive are registered, so they track the phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      bus_data_oe <= 1'b0;
    end else begin
      if (enter_e) begin
        rd_n <= is_write;
        wr_n <= ~is_write;
      end else if (e_end) begin
        rd_n <= 1'b1;
        wr_n <= 1'b1;
      end
      // write data driven from D (or E) through hold, off on the edge that enters idle
      if (cpu_tick) begin
        bus_data_oe <= is_write &&
          (next_state == bus_phase_pkg::PH_D ||
           next_state == bus_phase_pkg::PH_E ||
           next_state == bus_phase_pkg::PH_F);
      end
    end
  end

  // read data sampled on the very edge that raises rd_n
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= '0;
      done <= 1'b0;
    end else begin
      done <= cycle_end;
      if (e_end && !is_write) begin
        rdata <= bus_data_in;
      end
    end
  end
endmodule

/* rtl/bus_phase_pkg.sv */
package bus_phase_pkg;
  // field positions inside chip_select_timing_config
  localparam int AB_LSB = 0;   // base setup: 0 -> 1 period, 1 -> 2 periods
  localparam int AX_LSB = 1;   // 2 bits, extra setup on window change
  localparam int C_LSB = 3;    // 2 bits, command delay 0..3
  localparam int D_LSB = 5;    // 1 bit, write setup / turnaround 0..1
  localparam int E_LSB = 6;    // 5 bits, access length minus one
  localparam int F_LSB = 11;   // 2 bits, hold 0..3
  localparam int CFG_W = 13;
  localparam logic [12:0] CFG_RESET = 13'h0000;
  localparam int CNT_W = 5;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_AB = 3'b001,
    PH_C = 3'b010,
    PH_D = 3'b011,
    PH_E = 3'b100,
    PH_F = 3'b101
  } phase_t;
endpackage

/* rtl/cpu_clock_enable.sv */
`timescale 1ns/1ps
module cpu_clock_enable (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cpu_clock_halving_select,
  output logic cpu_tick
);
  logic half;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      half <= 1'b0;
    end else begin
      half <= ~half;
    end
  end
  // full rate when select is low, every other cycle when high
  assign cpu_tick = ~cpu_clock_halving_select | half;
endmodule

/* tb/bus_cycle_sequencer_properties.sv */
`timescale 1ns/1ps
module seq_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic req_ready,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic bus_data_oe,
  input wire logic [2:0] phase
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_one_strobe: assert property (rd_n | wr_n)
    else $error("two strobes");
  a_strobe_phase: assert property (
    !(rd_n & wr_n) |-> phase == 3'h4)
    else $error("strobe off access");
  a_idle_start: assert property (
    phase == 3'h0 |=> phase inside {3'h0, 3'h1})
    else $error("bad after idle");
  a_after_ab: assert property (
    phase == 3'h1 |=> phase inside {[3'h1:3'h4]})
    else $error("bad after setup");
  a_after_c: assert property (
    phase == 3'h2 |=> phase inside {[3'h2:3'h4]})
    else $error("bad after c");
  a_after_d: assert property (
    phase == 3'h3 |=> phase inside {3'h3, 3'h4})
    else $error("bad after d");
  a_after_e: assert property (
    phase == 3'h4 |=> phase inside {[3'h4:3'h5], 3'h0})
    else $error("bad after e");
  a_after_f: assert property (
    phase == 3'h5 |=> phase inside {3'h5, 3'h0})
    else $error("bad after f");
  a_busy_refused: assert property (phase != 3'h0 |-> !req_ready)
    else $error("ready while busy");
  a_write_drive: assert property (!wr_n |-> bus_data_oe)
    else $error("write not driven");
endmodule
bind bus_cycle_sequencer seq_chk u_chk (.ref_clk, .sys_rst, .req_ready,
  .rd_n, .wr_n, .bus_data_oe, .phase);

/* tb/bus_device_model.sv */
`timescale 1ns/1ps
module bus_device_model (
  input wire logic ref_clk,
  input wire logic rd_n,
  input wire logic [15:0] value,
  output logic [15:0] bus_data_in
);
  logic [15:0] last = 16'h0000;
  always @(posedge ref_clk) last <= bus_data_in;
  // released bus flips, so a late capture cannot pass by luck
  assign bus_data_in = rd_n ? ~last : value;
endmodule

/* tb/bus_cycle_sequencer_test.sv */
`timescale 1ns/1ps
module bus_cycle_sequencer_test;
  logic ref_clk = 0, sys_rst = 1, sel = 0, win = 0, valid = 0, wr = 0;
  logic [12:0] cfg = 13'h0000;
  logic [15:0] wd = 16'h0000, dv = 16'h0000, rdata, bdo, bdi;
  logic [23:0] ad = 24'h000000, ba;
  logic ready, done, oe, rd_n, wr_n;
  logic [2:0] phase;
  int num_errors = 0, tests_run = 0;
  initial forever #5 ref_clk = ~ref_clk;
  bus_cycle_sequencer u_dut (.ref_clk, .sys_rst,
    .cpu_clock_halving_select(sel), .chip_select_timing_config(cfg),
    .window_changed(win), .req_valid(valid), .req_write(wr),
    .req_addr(ad), .req_wdata(wd), .req_ready(ready), .done, .rdata,
    .bus_addr(ba), .bus_data_out(bdo), .bus_data_oe(oe),
    .bus_data_in(bdi), .rd_n, .wr_n, .phase);
  bus_device_model u_dev (.ref_clk, .rd_n, .value(dv), .bus_data_in(bdi));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // counts ref cycles per phase run; halving doubles every figure
  task automatic access(input logic w, x, s, input logic [12:0] c);
    int n, e, k, per, m;
    per = 2 + c[0] + (x ? c[2:1] : 0) + c[4:3] + c[5] + c[10:6] + c[12:11];
    m = s ? 2 : 1;
    n = 0;
    e = 0;
    k = 0;
    @(negedge ref_clk);
    {wr, win, sel, cfg, valid} = {w, x, s, c, 1'b1};
    wd = {3'h5, c};
    dv = ~wd;
    ad = {11'h2a5, c};
    while (phase === 3'h0 && k < 99) begin
      @(negedge ref_clk);
      k++;
    end
    valid = 0;
    while (phase !== 3'h0 && n < 200) begin
      n++;
      if (!(w ? wr_n : rd_n)) begin
        e++;
        check(ba, ad);
        if (w) check({oe, bdo}, {1'b1, wd});
        else check(oe, 1'b0);
      end
      @(negedge ref_clk);
    end
    check(n, per * m);
    check(e, (c[10:6] + 1) * m);
    k = 0;
    while (done !== 1'b1 && k < 3) begin
      @(negedge ref_clk);
      k++;
    end
    check(done, 1'b1);
    if (!w) check(rdata, dv);
  endtask
  task automatic t_min_read;
    access(0, 0, 0, 13'h0000);
  endtask
  task automatic t_max_write;
    access(1, 1, 0, 13'h1fff);
  endtask
  task automatic t_no_window;
    access(0, 0, 0, 13'h1fff);
  endtask
  task automatic t_halved;
    access(1, 1, 1, 13'h0a4b);
    access(0, 0, 1, 13'h1ffe);
  endtask
  task automatic t_turnaround;
    access(1, 0, 0, 13'h0820);
  endtask
  // reset mid-write must drop strobe and drive at once
  task automatic t_reset_mid;
    @(negedge ref_clk);
    {wr, win, sel, cfg, valid} = {1'b1, 1'b0, 1'b0, 13'h07c0, 1'b1};
    @(negedge ref_clk);
    valid = 0;
    @(negedge ref_clk);
    check({wr_n, oe}, 2'h1);
    sys_rst = 1;
    @(negedge ref_clk);
    check({ready, rd_n, wr_n, oe, done, phase}, 8'he0);
    check(ba, 24'h000000);
    check({bdo, rdata}, 32'h00000000);
    sys_rst = 0;
    access(0, 0, 0, 13'h0000);
  endtask
  initial begin
    #50000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    sys_rst = 0;
    t_min_read();
    t_max_write();
    t_no_window();
    t_halved();
    t_turnaround();
    t_reset_mid();
    report_and_stop();
  end
endmodule
